// [scrp_top.sv]
// What this block does
// - bytes travel most significant bit first
// - sample on clock rise, shift on fall
// - first byte: direction bit, seven-bit address
// - exactly two bytes per register transaction
// - select low in burst mode: FIFO write if transmit, else read
// - select high always means register transaction
// - register space spans 0x00 through 0x18
// - register 0 bit 7: receive or transmit
// - register 0 low bits: channel, default 0x28
// - two-bit transmit power level field
// - three-bit crystal frequency select field
// - register 2 bit 6: stream or burst
// - register 2 bit 5: bit rate select
// - register 2 bit 4: whitening enable
// - register 2 bit 3: checksum enable
// - register 2 bit 0: keep failed packets
// - refresh bit updates level in streaming
// - detect high when level exceeds threshold
// - register 4: gain control enable, gain
// - register 4 low bits report level
// - select low resets port, no increment
`timescale 1ns/1ps
`default_nettype none

`include "scrp_regs.svh"

module scrp_top (
	input  wire logic       ref_clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       ce_i,
	input  wire logic       sclk_i,
	input  wire logic       cs_i,
	input  wire logic       serial_data_io_i,
	output logic            serial_data_io_o,
	output logic            serial_data_io_oe_o,
	input  wire logic [3:0] analog_signal_level_i,
	output logic            signal_detect_out_o,
	input  wire logic [7:0] fifo_rd_data_i,
	output logic            fifo_rd_pop_o,
	output logic            fifo_wr_valid_o,
	output logic      [7:0] fifo_wr_data_o,
	output logic            tx_mode_o,
	output logic      [6:0] rf_channel_index_o,
	output logic      [1:0] tx_power_level_o,
	output logic      [2:0] crystal_freq_sel_o,
	output logic            burst_mode_o,
	output logic            bit_rate_sel_o,
	output logic            whitening_en_o,
	output logic            crc_en_o,
	output logic            crc_fail_keep_o,
	output logic            signal_level_refresh_o,
	output logic      [3:0] signal_level_threshold_o,
	output logic            agc_en_o,
	output logic            low_gain_o,
	output logic      [3:0] signal_level_value_o
);

	import scrp_pkg::*;

	logic [6:0]  sync_in;
	logic [6:0]  sync_out;
	logic        sclk_s;
	logic        cs_s;
	logic        serial_data_io_s;
	logic [3:0]  level_s;

	assign sync_in = {analog_signal_level_i, serial_data_io_i, cs_i, sclk_i};

	scrp_sync #(
		.W (7)
	) u_sync (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.async_i   (sync_in),
		.sync_o    (sync_out)
	);

	assign sclk_s  = sync_out[0];
	assign cs_s    = sync_out[1];
	assign serial_data_io_s  = sync_out[2];
	assign level_s = sync_out[6:3];

	// serial port state
	scrp_state_t state_r;
	scrp_state_t state_nxt;
	logic        sclk_q_r;
	logic        sclk_q_nxt;
	logic [2:0]  cnt_r;
	logic [2:0]  cnt_nxt;
	logic [7:0]  rx_r;
	logic [7:0]  rx_nxt;
	logic [7:0]  tx_r;
	logic [7:0]  tx_nxt;
	logic [6:0]  addr_r;
	logic [6:0]  addr_nxt;
	logic        wr_r;
	logic        wr_nxt;
	logic        out_r;
	logic        out_nxt;
	logic        oe_r;
	logic        oe_nxt;
	logic        pop_r;
	logic        pop_nxt;
	logic        fwv_r;
	logic        fwv_nxt;
	logic [7:0]  fwd_r;
	logic [7:0]  fwd_nxt;

	// register file
	logic [7:0]  reg0_r;
	logic [7:0]  reg0_nxt;
	logic [7:0]  reg1_r;
	logic [7:0]  reg1_nxt;
	logic [7:0]  reg2_r;
	logic [7:0]  reg2_nxt;
	logic [7:0]  reg3_r;
	logic [7:0]  reg3_nxt;
	logic [3:0]  ctl4_r;
	logic [3:0]  ctl4_nxt;
	logic [3:0]  val_r;
	logic [3:0]  val_nxt;
	logic        det_r;
	logic        det_nxt;

	logic        sclk_rise;
	logic        sclk_fall;
	logic [7:0]  shin;
	logic        byte_end;
	logic        do_write;
	logic [7:0]  wdata;

	assign sclk_rise = sclk_s & ~sclk_q_r;
	assign sclk_fall = ~sclk_s & sclk_q_r;
	assign shin      = {rx_r[6:0], serial_data_io_s};
	assign byte_end  = (cnt_r == `SCRP_LAST_BIT);

	function automatic logic [7:0] read_mux(input logic [6:0] a);
		case (a)
			`SCRP_ADDR_DIR_CHAN:  read_mux = reg0_r;
			`SCRP_ADDR_PWR_XTAL:  read_mux = reg1_r;
			`SCRP_ADDR_DATA_FUNC: read_mux = reg2_r;
			`SCRP_ADDR_LVL_CTRL:  read_mux = reg3_r;
			`SCRP_ADDR_LVL_VALUE: read_mux = {ctl4_r, val_r};
			default:              read_mux = 8'h00;
		endcase
	endfunction

	always_comb begin
		state_nxt  = state_r;
		sclk_q_nxt = sclk_s;
		cnt_nxt    = cnt_r;
		rx_nxt     = rx_r;
		tx_nxt     = tx_r;
		addr_nxt   = addr_r;
		wr_nxt     = wr_r;
		out_nxt    = out_r;
		oe_nxt     = oe_r;
		pop_nxt    = 1'b0;
		fwv_nxt    = 1'b0;
		fwd_nxt    = fwd_r;
		do_write   = 1'b0;
		wdata      = shin;
		if (cs_s) begin
			case (state_r)
				SCRP_ST_IDLE, SCRP_ST_FIFO_WR, SCRP_ST_FIFO_RD: begin
					// bits clocked with select high are always config
					state_nxt = SCRP_ST_ADDR;
					cnt_nxt   = 3'h0;
					oe_nxt    = 1'b0;
				end
				SCRP_ST_ADDR: begin
					if (sclk_rise) begin
						rx_nxt  = shin;
						cnt_nxt = cnt_r + 3'h1;
						if (byte_end) begin
							wr_nxt    = shin[`SCRP_BIT_RW];
							addr_nxt  = shin[6:0];
							state_nxt = SCRP_ST_DATA;
							if (!shin[`SCRP_BIT_RW]) begin
								tx_nxt = read_mux(shin[6:0]);
							end
						end
					end
				end
				SCRP_ST_DATA: begin
					if (sclk_rise) begin
						rx_nxt  = shin;
						cnt_nxt = cnt_r + 3'h1;
						if (byte_end) begin
							// no auto-increment: wait for select to drop
							state_nxt = SCRP_ST_DONE;
							oe_nxt    = 1'b0;
							do_write  = wr_r;
						end
					end else if (sclk_fall && !wr_r) begin
						out_nxt = tx_r[7];
						tx_nxt  = {tx_r[6:0], 1'b0};
						oe_nxt  = 1'b1;
					end
				end
				SCRP_ST_DONE: begin
					oe_nxt = 1'b0;
				end
				default: begin
					state_nxt = SCRP_ST_IDLE;
				end
			endcase
		end else begin
			case (state_r)
				SCRP_ST_FIFO_WR: begin
					if (sclk_rise) begin
						rx_nxt  = shin;
						cnt_nxt = cnt_r + 3'h1;
						if (byte_end) begin
							fwv_nxt = 1'b1;
							fwd_nxt = shin;
						end
					end
				end
				SCRP_ST_FIFO_RD: begin
					if (sclk_rise) begin
						cnt_nxt = cnt_r + 3'h1;
						if (byte_end) begin
							tx_nxt  = fifo_rd_data_i;
							pop_nxt = 1'b1;
						end
					end else if (sclk_fall) begin
						out_nxt = tx_r[7];
						tx_nxt  = {tx_r[6:0], 1'b0};
						oe_nxt  = 1'b1;
					end
				end
				default: begin
					// select low resets the port; burst mode picks FIFO
					cnt_nxt = 3'h0;
					oe_nxt  = 1'b0;
					if (!reg2_r[`SCRP_BIT_BURST]) begin
						state_nxt = SCRP_ST_IDLE;
					end else if (reg0_r[`SCRP_BIT_TX_MODE]) begin
						state_nxt = SCRP_ST_FIFO_WR;
					end else begin
						// first bit must stand before the first rise
						state_nxt = SCRP_ST_FIFO_RD;
						out_nxt   = fifo_rd_data_i[7];
						tx_nxt    = {fifo_rd_data_i[6:0], 1'b0};
						oe_nxt    = 1'b1;
						pop_nxt   = 1'b1;
					end
				end
			endcase
		end
		if (!ce_i) begin
			state_nxt  = state_r;
			sclk_q_nxt = sclk_q_r;
			cnt_nxt    = cnt_r;
			rx_nxt     = rx_r;
			tx_nxt     = tx_r;
			addr_nxt   = addr_r;
			wr_nxt     = wr_r;
			out_nxt    = out_r;
			oe_nxt     = oe_r;
			pop_nxt    = pop_r;
			fwv_nxt    = fwv_r;
			fwd_nxt    = fwd_r;
			do_write   = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_r  <= SCRP_ST_IDLE;
			sclk_q_r <= 1'b0;
			cnt_r    <= 3'h0;
			rx_r     <= 8'h00;
			tx_r     <= 8'h00;
			addr_r   <= 7'h00;
			wr_r     <= 1'b0;
			out_r    <= 1'b0;
			oe_r     <= 1'b0;
			pop_r    <= 1'b0;
			fwv_r    <= 1'b0;
			fwd_r    <= 8'h00;
		end else begin
			state_r  <= state_nxt;
			sclk_q_r <= sclk_q_nxt;
			cnt_r    <= cnt_nxt;
			rx_r     <= rx_nxt;
			tx_r     <= tx_nxt;
			addr_r   <= addr_nxt;
			wr_r     <= wr_nxt;
			out_r    <= out_nxt;
			oe_r     <= oe_nxt;
			pop_r    <= pop_nxt;
			fwv_r    <= fwv_nxt;
			fwd_r    <= fwd_nxt;
		end
	end

	// register file and level tracking
	always_comb begin
		reg0_nxt = reg0_r;
		reg1_nxt = reg1_r;
		reg2_nxt = reg2_r;
		reg3_nxt = reg3_r;
		ctl4_nxt = ctl4_r;
		val_nxt  = val_r;
		det_nxt  = det_r;
		if (ce_i) begin
			if (do_write) begin
				// reserved bits stored as written; host keeps them zero
				case (addr_r)
					`SCRP_ADDR_DIR_CHAN:  reg0_nxt = wdata;
					`SCRP_ADDR_PWR_XTAL:  reg1_nxt = wdata;
					`SCRP_ADDR_DATA_FUNC: reg2_nxt = wdata;
					`SCRP_ADDR_LVL_CTRL:  reg3_nxt = wdata;
					`SCRP_ADDR_LVL_VALUE: begin
						// level bits are measured, not writable
						ctl4_nxt = wdata[`SCRP_CTRL_HI:`SCRP_CTRL_LO];
					end
					default: begin
						reg0_nxt = reg0_r;
					end
				endcase
			end
			// refresh bit only matters in streaming mode
			if (reg2_r[`SCRP_BIT_BURST] || reg3_r[`SCRP_BIT_REFRESH]) begin
				val_nxt = level_s;
			end
			det_nxt = (level_s > reg3_r[`SCRP_THR_HI:`SCRP_THR_LO]);
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			reg0_r <= `SCRP_RST_DIR_CHAN;
			reg1_r <= `SCRP_RST_PWR_XTAL;
			reg2_r <= `SCRP_RST_DATA_FUNC;
			reg3_r <= `SCRP_RST_LVL_CTRL;
			ctl4_r <= 4'(`SCRP_RST_LVL_VALUE >> 4);
			val_r  <= 4'h0;
			det_r  <= 1'b0;
		end else begin
			reg0_r <= reg0_nxt;
			reg1_r <= reg1_nxt;
			reg2_r <= reg2_nxt;
			reg3_r <= reg3_nxt;
			ctl4_r <= ctl4_nxt;
			val_r  <= val_nxt;
			det_r  <= det_nxt;
		end
	end

	assign serial_data_io_o         = out_r;
	assign serial_data_io_oe_o      = oe_r;
	assign signal_detect_out_o      = det_r;
	assign fifo_rd_pop_o            = pop_r;
	assign fifo_wr_valid_o          = fwv_r;
	assign fifo_wr_data_o           = fwd_r;
	assign tx_mode_o                = reg0_r[`SCRP_BIT_TX_MODE];
	assign rf_channel_index_o       = reg0_r[`SCRP_CHAN_HI:`SCRP_CHAN_LO];
	assign tx_power_level_o         = reg1_r[`SCRP_PWR_HI:`SCRP_PWR_LO];
	assign crystal_freq_sel_o       = reg1_r[`SCRP_XTAL_HI:`SCRP_XTAL_LO];
	assign burst_mode_o             = reg2_r[`SCRP_BIT_BURST];
	assign bit_rate_sel_o           = reg2_r[`SCRP_BIT_RATE];
	assign whitening_en_o           = reg2_r[`SCRP_BIT_WHITEN];
	assign crc_en_o                 = reg2_r[`SCRP_BIT_CRC_EN];
	assign crc_fail_keep_o          = reg2_r[`SCRP_BIT_CRC_KEEP];
	assign signal_level_refresh_o   = reg3_r[`SCRP_BIT_REFRESH];
	assign signal_level_threshold_o = reg3_r[`SCRP_THR_HI:`SCRP_THR_LO];
	assign agc_en_o                 = ctl4_r[`SCRP_BIT_AGC_EN - 4];
	assign low_gain_o               = ctl4_r[`SCRP_BIT_LOW_GAIN - 4];
	assign signal_level_value_o     = val_r;

endmodule

`default_nettype wire

// [scrp_regs.svh]
`ifndef SCRP_REGS_SVH
`define SCRP_REGS_SVH

// register addresses
`define SCRP_ADDR_DIR_CHAN      7'h00
`define SCRP_ADDR_PWR_XTAL      7'h01
`define SCRP_ADDR_DATA_FUNC     7'h02
`define SCRP_ADDR_LVL_CTRL      7'h03
`define SCRP_ADDR_LVL_VALUE     7'h04
`define SCRP_ADDR_LAST          7'h18

// power-up values
`define SCRP_RST_DIR_CHAN       8'h28
`define SCRP_RST_PWR_XTAL       8'h03
`define SCRP_RST_DATA_FUNC      8'h78
`define SCRP_RST_LVL_CTRL       8'h87
`define SCRP_RST_LVL_VALUE      8'h20

// field positions
`define SCRP_BIT_RW             7
`define SCRP_BIT_TX_MODE        7
`define SCRP_CHAN_HI            6
`define SCRP_CHAN_LO            0
`define SCRP_PWR_HI             4
`define SCRP_PWR_LO             3
`define SCRP_XTAL_HI            2
`define SCRP_XTAL_LO            0
`define SCRP_BIT_BURST          6
`define SCRP_BIT_RATE           5
`define SCRP_BIT_WHITEN         4
`define SCRP_BIT_CRC_EN         3
`define SCRP_BIT_CRC_KEEP       0
`define SCRP_BIT_REFRESH        4
`define SCRP_THR_HI             3
`define SCRP_THR_LO             0
`define SCRP_BIT_AGC_EN         5
`define SCRP_BIT_LOW_GAIN       4
`define SCRP_VAL_HI             3
`define SCRP_VAL_LO             0
`define SCRP_CTRL_HI            7
`define SCRP_CTRL_LO            4

// serial framing
`define SCRP_LAST_BIT           3'h7

`endif

// [scrp_pkg.sv]
`default_nettype none

package scrp_pkg;

	typedef enum logic [2:0] {
		SCRP_ST_IDLE,
		SCRP_ST_ADDR,
		SCRP_ST_DATA,
		SCRP_ST_DONE,
		SCRP_ST_FIFO_WR,
		SCRP_ST_FIFO_RD
	} scrp_state_t;

endpackage

`default_nettype wire

// [scrp_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module scrp_sync #(
	parameter int W = 7
) (
	input  wire logic         ref_clk_i,
	input  wire logic         sys_rst_i,
	input  wire logic         ce_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			logic meta_r;
			logic meta_nxt;
			logic hold_r;
			logic hold_nxt;

			// first stage feeds only the second
			always_comb begin
				meta_nxt = ce_i ? async_i[g] : meta_r;
				hold_nxt = ce_i ? meta_r : hold_r;
			end

			always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
				if (sys_rst_i) begin
					meta_r <= 1'b0;
					hold_r <= 1'b0;
				end else begin
					meta_r <= meta_nxt;
					hold_r <= hold_nxt;
				end
			end

			assign sync_o[g] = hold_r;
		end
	endgenerate

endmodule

`default_nettype wire

// [scrp_chk_sva.sv]
`timescale 1ns/1ps
`default_nettype none

module scrp_chk (
	input wire logic       ref_clk_i,
	input wire logic       sys_rst_i,
	input wire logic       sclk_i,
	input wire logic       cs_i,
	input wire logic       serial_data_io_o,
	input wire logic       serial_data_io_oe_o,
	input wire logic [3:0] analog_signal_level_i,
	input wire logic       signal_detect_out_o,
	input wire logic       fifo_rd_pop_o,
	input wire logic       fifo_wr_valid_o,
	input wire logic       tx_mode_o,
	input wire logic [6:0] rf_channel_index_o,
	input wire logic       burst_mode_o,
	input wire logic       signal_level_refresh_o,
	input wire logic [3:0] signal_level_threshold_o,
	input wire logic [3:0] signal_level_value_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);

	// level must settle past the synchroniser first
	sequence lvl_settled;
		($stable(analog_signal_level_i)
			&& $stable(signal_level_threshold_o))[*6];
	endsequence
	sequence lvl_tracked;
		((burst_mode_o || signal_level_refresh_o)
			&& $stable(analog_signal_level_i))[*6];
	endsequence

	AST_DETECT: assert property (lvl_settled |-> signal_detect_out_o ==
		(analog_signal_level_i > signal_level_threshold_o))
		else $error("detect output disagrees with threshold");
	AST_VAL_TRACK: assert property (lvl_tracked |->
		signal_level_value_o == analog_signal_level_i)
		else $error("level value does not follow input");
	AST_VAL_HOLD: assert property (!burst_mode_o &&
		!signal_level_refresh_o |=> $stable(signal_level_value_o))
		else $error("level value changed while held");
	AST_NO_FIFO_CONT: assert property (!burst_mode_o &&
		!$past(burst_mode_o, 2) |-> !fifo_rd_pop_o && !fifo_wr_valid_o)
		else $error("fifo activity in continuous mode");
	AST_NO_FIFO_CS: assert property (cs_i[*6] |->
		!fifo_rd_pop_o && !fifo_wr_valid_o)
		else $error("fifo activity with select high");
	AST_OE_IDLE: assert property ((!cs_i && !burst_mode_o)[*6] |->
		!serial_data_io_oe_o)
		else $error("data line driven outside a read");
	AST_OE_RISE: assert property ($rose(serial_data_io_oe_o) |->
		!sclk_i)
		else $error("drive started while serial clock high");
	AST_SHIFT_FALL: assert property (serial_data_io_oe_o &&
		$past(serial_data_io_oe_o) && $changed(serial_data_io_o) |->
		!sclk_i)
		else $error("output bit changed while serial clock high");
	AST_CFG_CS: assert property ($changed({tx_mode_o,
		rf_channel_index_o, burst_mode_o, signal_level_refresh_o,
		signal_level_threshold_o}) |-> $past(cs_i, 4))
		else $error("register changed without a register access");
endmodule

bind scrp_top scrp_chk u_chk (.*);

`default_nettype wire

// [scrp_host.sv]
`timescale 1ns/1ps
`default_nettype none

// link clock idles low outside frames
module scrp_host (
	output logic      sclk_o,
	output logic      cs_o,
	output logic      line_o,
	input  wire logic dev_d_i,
	input  wire logic dev_oe_i
);
	logic hd;
	logic hoe;
	logic last;
	initial begin
		sclk_o = 1'b0;
		cs_o = 1'b0;
		hd = 1'b0;
		hoe = 1'b0;
		last = 1'b0;
	end
	// released line shows the inverse of its last driven level
	assign line_o = dev_oe_i ? dev_d_i : (hoe ? hd : ~last);
	always @(line_o)
		if (dev_oe_i || hoe)
			last = line_o;

	task automatic xfer(
		input  logic [31:0] b,
		input  logic [31:0] drv,
		input  int          n,
		input  logic        cs,
		output logic [7:0]  q
	);
		q = 8'h00;
		cs_o = cs;
		#200;
		for (int i = 0; i < n; i++) begin
			// host lets go of the line wherever the device answers
			hoe = drv[31 - i];
			hd = b[31 - i];
			#40 sclk_o = 1'b1;
			if (!hoe)
				q = {q[6:0], line_o};
			#40 sclk_o = 1'b0;
		end
		hoe = 1'b0;
		#60 cs_o = 1'b0;
		#200;
	endtask
endmodule

`default_nettype wire

// [scrp_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none

`include "scrp_regs.svh"

module scrp_top_tb;
	logic        ref_clk_i;
	logic        sys_rst_i;
	logic [3:0]  lvl = 4'h0;
	logic [7:0]  q;
	logic [7:0]  wr_cap = 8'h00;
	wire logic   sclk, cs, line, sdo, soe, wr_v, tx, bu, ra, wh, cr, kp, det;
	wire logic   pop, ag, lg;
	logic [7:0]  head = 8'hA5;
	int          pops = 0;
	int          p0 = 0;
	wire logic [7:0] wr_d;
	wire logic [6:0] ch;
	wire logic [1:0] pw;
	wire logic [2:0] xt;
	int          errors = 0;
	int          tests_run = 0;
	// addr, write data, expected readback
	logic [23:0] rows [7] = '{24'h00FFFF, 24'h011F1F, 24'h024949,
		24'h031A1A, 24'h05AA00, 24'h7F5500, 24'h000101};
	logic [7:0]  rv [5] = '{`SCRP_RST_DIR_CHAN, `SCRP_RST_PWR_XTAL,
		`SCRP_RST_DATA_FUNC, `SCRP_RST_LVL_CTRL, `SCRP_RST_LVL_VALUE};

	scrp_host host (.sclk_o(sclk), .cs_o(cs), .line_o(line),
		.dev_d_i(sdo), .dev_oe_i(soe));

	scrp_top DUT (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.ce_i(1'b1), .sclk_i(sclk), .cs_i(cs), .serial_data_io_i(line),
		.serial_data_io_o(sdo), .serial_data_io_oe_o(soe),
		.analog_signal_level_i(lvl), .signal_detect_out_o(det),
		.fifo_rd_data_i(head), .fifo_rd_pop_o(pop), .fifo_wr_valid_o(wr_v),
		.fifo_wr_data_o(wr_d), .tx_mode_o(tx), .rf_channel_index_o(ch),
		.tx_power_level_o(pw), .crystal_freq_sel_o(xt),
		.burst_mode_o(bu), .bit_rate_sel_o(ra), .whitening_en_o(wh),
		.crc_en_o(cr), .crc_fail_keep_o(kp), .signal_level_refresh_o(),
		.signal_level_threshold_o(), .agc_en_o(ag), .low_gain_o(lg),
		.signal_level_value_o());

	always @(posedge ref_clk_i)
		if (wr_v === 1'b1)
			wr_cap <= wr_d;
	always @(posedge ref_clk_i)
		if (pop === 1'b1)
			pops <= pops + 1;

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t ns: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] x;
		host.xfer({1'b1, a, d, 16'h0000}, 32'hFFFF_FFFF, 16, 1'b1, x);
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		host.xfer({1'b0, a, 8'h00, 16'h0000}, 32'hFF00_FFFF, 16, 1'b1, d);
	endtask
	task automatic settle(input logic [3:0] v);
		@(posedge ref_clk_i);
		#1 lvl = v;
		repeat (10) @(posedge ref_clk_i);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end
	initial begin
		#300000;
		errors++;
		complete_run();
	end
	initial begin
		sys_rst_i = 1'b1;
		repeat (12) @(posedge ref_clk_i);
		#1 sys_rst_i = 1'b0;
		for (int k = 0; k < 7; k++) begin
			wr(rows[k][22:16], rows[k][15:8]);
			rd(rows[k][22:16], q);
			chk(q, rows[k][7:0]);
		end
		chk({tx, ch}, 8'h01);
		chk({3'b000, pw, xt}, 8'h1F);
		chk({1'b0, bu, ra, wh, cr, 2'b00, kp}, 8'h49);
		$display("test rows done");
		@(posedge ref_clk_i);
		#1 sys_rst_i = 1'b1;
		repeat (12) @(posedge ref_clk_i);
		#1 sys_rst_i = 1'b0;
		for (int k = 0; k < 5; k++) begin
			rd(k[6:0], q);
			chk(q, rv[k]);
		end
		chk({6'h00, ag, lg}, 8'h02);
		$display("test reset done");
		settle(4'h8);
		chk({7'h00, det}, 8'h01);
		rd(`SCRP_ADDR_LVL_VALUE, q);
		chk(q, 8'h28);
		settle(4'h7);
		chk({7'h00, det}, 8'h00);
		wr(`SCRP_ADDR_DATA_FUNC, 8'h38);
		wr(`SCRP_ADDR_LVL_CTRL, 8'h07);
		settle(4'h3);
		wr(`SCRP_ADDR_LVL_VALUE, 8'h10);
		chk({6'h00, ag, lg}, 8'h01);
		rd(`SCRP_ADDR_LVL_VALUE, q);
		chk(q, 8'h17);
		wr(`SCRP_ADDR_LVL_CTRL, 8'h17);
		settle(4'h3);
		rd(`SCRP_ADDR_LVL_VALUE, q);
		chk(q, 8'h13);
		$display("test level done");
		// extra bits under one select must not start a second access
		host.xfer({1'b1, `SCRP_ADDR_PWR_XTAL, 8'h0A, 8'h81, 8'h15},
			32'hFFFF_FFFF, 32, 1'b1, q);
		rd(`SCRP_ADDR_PWR_XTAL, q);
		chk(q, 8'h0A);
		$display("test no increment done");
		wr(`SCRP_ADDR_DATA_FUNC, 8'h40);
		wr(`SCRP_ADDR_DIR_CHAN, 8'hA8);
		host.xfer({8'hC3, 24'h000000}, 32'hFF00_0000, 8, 1'b0, q);
		chk(wr_cap, 8'hC3);
		$display("test fifo write done");
		// receive mode: first byte loaded as select drops
		wr(`SCRP_ADDR_DIR_CHAN, 8'h28);
		head = 8'h3C;
		p0 = pops;
		host.xfer(32'h0000_0000, 32'h0000_0000, 8, 1'b0, q);
		chk(q, 8'hA5);
		host.xfer(32'h0000_0000, 32'h0000_0000, 8, 1'b0, q);
		chk(q, 8'h3C);
		chk(8'(pops - p0), 8'h02);
		$display("test fifo read done");
		complete_run();
	end
endmodule

`default_nettype wire
